// ===== port_pin_function_mux.v
// Pin function multiplexer for two general-purpose ports
// Functional notes
// - Pins are port I/O until function selected
// - External clock outranks analog channel zero
// - Pin-change plus analog keeps input buffer
// - Comparator output keeps shared inputs connected
// - Compare B output still feeds analog
// - Clock output beats compare A on pin
// - Reset or programming forces all inputs
// - Remap moves timer pins to alternates
// - Drivers released immediately on reset condition
// - Reset pin usable as weak I/O
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_regs.vh"
module port_pin_function_mux (
  // Clock and reset
  input  wire                    ref_clk,
  input  wire                    srst,
  input  wire                    reset_cond,
  // Register port
  input  wire [`ADDR_W-1:0]      reg_addr,
  input  wire [`DATA_W-1:0]      reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [`DATA_W-1:0]      reg_rdata,
  // Programming mode
  input  wire                    prog_active,
  // Peripheral outputs toward pins
  input  wire                    clock_output_pin_fn,
  input  wire                    timer_compare_output_a,
  input  wire                    timer_oca_en,
  input  wire                    timer_compare_output_b,
  input  wire                    timer_ocb_en,
  input  wire                    serial_transmit_line,
  input  wire                    serial_sync_clock,
  input  wire                    comparator_result_out,
  // Pads
  input  wire [`NUM_PINS-1:0]    pad_in,
  output wire [`NUM_PINS-1:0]    pad_out,
  output wire [`NUM_PINS-1:0]    pad_oe,
  output wire [`NUM_PINS-1:0]    pad_ibuf_en,
  output reg                     reset_pin_weak,
  // Peripheral inputs from pins
  output reg                     clock_input_pin_fn,
  output reg                     prog_if_clock,
  output reg                     prog_if_data,
  output reg                     timer_count_input,
  output reg                     timer_capture_input,
  output reg                     serial_receive_line,
  output reg                     external_irq_zero,
  output reg  [`NUM_PINS-1:0]    pin_change_irq_lines,
  output reg  [7:0]              analog_channel_switch,
  output reg                     comparator_pos_input,
  output reg                     comparator_neg_input
);
  reg  [7:0]           porta_data_q;
  reg  [7:0]           porta_dir_q;
  reg  [3:0]           portb_data_q;
  reg  [3:0]           portb_dir_q;
  reg  [7:0]           digital_input_disable_reg;
  reg  [7:0]           func_ctrl_q;
  reg  [7:0]           pin_change_irq_lines_a_q;
  reg  [3:0]           pin_change_irq_lines_b_q;
  reg  [7:0]           analog_ctrl_q;
  reg  [`NUM_PINS-1:0] alt_sel;
  reg  [`NUM_PINS-1:0] alt_val;
  reg  [`NUM_PINS-1:0] keep_buf;
  reg  [`NUM_PINS-1:0] didr_map;
  reg  [7:0]           rdata_d;
  wire [`NUM_PINS-1:0] pin_in;
  wire [`NUM_PINS-1:0] port_val;
  wire [`NUM_PINS-1:0] port_dir;
  wire [`NUM_PINS-1:0] pin_change_irq_lines_en;
  wire [`NUM_PINS-1:0] force_in;
  wire                 external_clock_select;
  wire                 clk_out_en;
  wire                 remap;
  wire                 serial_en;
  wire                 xck_out;
  wire                 aco_out;
  wire                 rst_gpio;
  wire [2:0]           adc_ch;
  wire                 adc_en;
  wire                 cmp_en;
  wire                 hold_inputs;

  assign external_clock_select = func_ctrl_q[`FC_EXTERNAL_CLOCK_SELECT];
  assign clk_out_en = func_ctrl_q[`FC_CLK_OUT];
  assign remap      = func_ctrl_q[`FC_REMAP];
  assign serial_en  = func_ctrl_q[`FC_SERIAL_EN];
  assign xck_out    = func_ctrl_q[`FC_XCK_OUT];
  assign aco_out    = func_ctrl_q[`FC_ACO_OUT];
  assign rst_gpio   = func_ctrl_q[`FC_RST_GPIO];
  assign adc_ch     = analog_ctrl_q[`AC_CH_MSB:`AC_CH_LSB];
  assign adc_en     = analog_ctrl_q[`AC_ADC_EN];
  assign cmp_en     = analog_ctrl_q[`AC_CMP_EN];
  assign port_val   = {portb_data_q, porta_data_q};
  assign port_dir   = {portb_dir_q, porta_dir_q};
  assign pin_change_irq_lines_en   = {pin_change_irq_lines_b_q, pin_change_irq_lines_a_q};

  assign hold_inputs = srst | prog_active;
  // reset pin driven only in its I/O role
  assign force_in = {`NUM_PINS{hold_inputs}} |
                    ({{(`NUM_PINS-1){1'b0}}, ~rst_gpio} << `PIN_PA2);

  // Register writes; nothing but a write or srst changes a setting
  always @(posedge ref_clk) begin
    if (srst) begin
      // reset leaves every pin but PA2, the reset pin, to the port
      porta_data_q              <= `RST_BYTE;
      porta_dir_q               <= `RST_BYTE;
      portb_data_q              <= 4'h0;
      portb_dir_q               <= 4'h0;
      digital_input_disable_reg <= `RST_BYTE;
      func_ctrl_q               <= `RST_BYTE;
      pin_change_irq_lines_a_q                 <= `RST_BYTE;
      pin_change_irq_lines_b_q                 <= 4'h0;
      analog_ctrl_q             <= `RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_PORTA_DATA:  porta_data_q <= reg_wdata;
        `OFS_PORTA_DIR:   porta_dir_q <= reg_wdata;
        `OFS_PORTB_DATA:  portb_data_q <= reg_wdata[3:0];
        `OFS_PORTB_DIR:   portb_dir_q <= reg_wdata[3:0];
        `OFS_DIDR:        digital_input_disable_reg <= reg_wdata;
        `OFS_FUNC_CTRL:   func_ctrl_q <= {1'b0, reg_wdata[6:0]};
        `OFS_PIN_CHANGE_IRQ_LINES_A:     pin_change_irq_lines_a_q <= reg_wdata;
        `OFS_PIN_CHANGE_IRQ_LINES_B:     pin_change_irq_lines_b_q <= reg_wdata[3:0];
        `OFS_ANALOG_CTRL: analog_ctrl_q <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  always @* begin
    case (reg_addr)
      `OFS_PORTA_DATA:  rdata_d = porta_data_q;
      `OFS_PORTA_DIR:   rdata_d = porta_dir_q;
      `OFS_PORTB_DATA:  rdata_d = {4'h0, portb_data_q};
      `OFS_PORTB_DIR:   rdata_d = {4'h0, portb_dir_q};
      `OFS_DIDR:        rdata_d = digital_input_disable_reg;
      `OFS_FUNC_CTRL:   rdata_d = func_ctrl_q;
      `OFS_PIN_CHANGE_IRQ_LINES_A:     rdata_d = pin_change_irq_lines_a_q;
      `OFS_PIN_CHANGE_IRQ_LINES_B:     rdata_d = {4'h0, pin_change_irq_lines_b_q};
      `OFS_ANALOG_CTRL: rdata_d = analog_ctrl_q;
      `OFS_PINS_A:      rdata_d = pin_in[7:0];
      `OFS_PINS_B:      rdata_d = {4'h0, pin_in[11:8]};
      `OFS_STATUS:      rdata_d = {5'h00, remap, external_clock_select,
                                   prog_active};
      default:          rdata_d = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : 8'h00;
    end
  end

  // Output function selection per pin
  always @* begin
    alt_sel = {`NUM_PINS{1'b0}};
    alt_val = {`NUM_PINS{1'b0}};
    // compare outputs follow the remap option
    if (timer_ocb_en) begin
      alt_sel[remap ? `PIN_PA5 : `PIN_PA1] = 1'b1;
      alt_val[remap ? `PIN_PA5 : `PIN_PA1] = timer_compare_output_b;
    end
    if (timer_oca_en && remap) begin
      alt_sel[`PIN_PA3] = 1'b1;
      alt_val[`PIN_PA3] = timer_compare_output_a;
    end
    if (clk_out_en) begin
      alt_sel[`PIN_PB1] = 1'b1;
      alt_val[`PIN_PB1] = clock_output_pin_fn;
    end else if (serial_en && xck_out) begin
      alt_sel[`PIN_PB1] = 1'b1;
      alt_val[`PIN_PB1] = serial_sync_clock;
    end else if (timer_oca_en && !remap) begin
      alt_sel[`PIN_PB1] = 1'b1;
      alt_val[`PIN_PB1] = timer_compare_output_a;
    end
    // transmit driver ignores the input disable
    if (serial_en) begin
      alt_sel[`PIN_PB2] = 1'b1;
      alt_val[`PIN_PB2] = serial_transmit_line;
    end
    if (aco_out) begin
      alt_sel[`PIN_PB3] = 1'b1;
      alt_val[`PIN_PB3] = comparator_result_out;
    end
  end

  // Input buffer disable per pin and the conditions that overrule it
  always @* begin
    didr_map = {digital_input_disable_reg[7:4], 1'b0,
                digital_input_disable_reg[3:2], 3'b000,
                digital_input_disable_reg[1:0]};
    keep_buf = pin_change_irq_lines_en;
    keep_buf[`PIN_PA0] = pin_change_irq_lines_en[`PIN_PA0] | external_clock_select;
    keep_buf[`PIN_PB3] = pin_change_irq_lines_en[`PIN_PB3] | aco_out;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_PINS; gi = gi + 1) begin : g_pin
      pin_cell u_cell (
        .ref_clk     (ref_clk),
        .srst        (srst),
        .reset_cond  (reset_cond),
        .force_input (force_in[gi]),
        .port_val    (port_val[gi]),
        .port_dir    (port_dir[gi]),
        .alt_sel     (alt_sel[gi]),
        .alt_val     (alt_val[gi]),
        .keep_buffer (keep_buf[gi]),
        .didr_bit    (didr_map[gi]),
        .pad_in      (pad_in[gi]),
        .pad_out     (pad_out[gi]),
        .pad_oe      (pad_oe[gi]),
        .ibuf_en     (pad_ibuf_en[gi]),
        .in_q        (pin_in[gi])
      );
    end
  endgenerate

  // Routing pin levels to peripherals, registered
  always @(posedge ref_clk) begin
    if (srst) begin
      clock_input_pin_fn    <= 1'b0;
      prog_if_clock         <= 1'b0;
      prog_if_data          <= 1'b0;
      timer_count_input     <= 1'b0;
      timer_capture_input   <= 1'b0;
      serial_receive_line   <= 1'b0;
      external_irq_zero     <= 1'b0;
      pin_change_irq_lines  <= `RST_PINS;
      analog_channel_switch <= 8'h00;
      comparator_pos_input  <= 1'b0;
      comparator_neg_input  <= 1'b0;
      reset_pin_weak        <= 1'b0;
    end else begin
      clock_input_pin_fn    <= external_clock_select & pin_in[`PIN_PA0];
      prog_if_clock         <= prog_active & pin_in[`PIN_PA0];
      prog_if_data          <= prog_active & pin_in[`PIN_PA1];
      // count and capture inputs follow remap
      timer_count_input     <= remap ? pin_in[`PIN_PB3] : pin_in[`PIN_PA0];
      timer_capture_input   <= remap ? pin_in[`PIN_PA4] : pin_in[`PIN_PB2];
      // receive input stays on while comparator drives
      serial_receive_line   <= serial_en & pin_in[`PIN_PB3];
      external_irq_zero     <= pin_in[`PIN_PB1];
      pin_change_irq_lines  <= pin_in & pin_change_irq_lines_en;
      // analog switch independent of driver use
      // channel zero disconnected under external clock
      analog_channel_switch <= (adc_en &&
                                !(adc_ch == 3'h0 && external_clock_select))
                               ? (8'h01 << adc_ch) : 8'h00;
      comparator_pos_input  <= cmp_en & ~external_clock_select &
                               pad_in[`PIN_PA0];
      comparator_neg_input  <= cmp_en & pad_in[`PIN_PA1];
      // reset pin acts as a weak I/O
      reset_pin_weak        <= rst_gpio;
    end
  end
endmodule
`default_nettype wire

// ===== pin_mux_regs.vh
// Register offsets, field positions and reset values of the pin multiplexer
`ifndef PIN_MUX_REGS_VH
`define PIN_MUX_REGS_VH

`define ADDR_W            4
`define DATA_W            8
`define NUM_PINS          12

`define OFS_PORTA_DATA    4'h0
`define OFS_PORTA_DIR     4'h1
`define OFS_PORTB_DATA    4'h2
`define OFS_PORTB_DIR     4'h3
`define OFS_DIDR          4'h4
`define OFS_FUNC_CTRL     4'h5
`define OFS_PIN_CHANGE_IRQ_LINES_A       4'h6
`define OFS_PIN_CHANGE_IRQ_LINES_B       4'h7
`define OFS_ANALOG_CTRL   4'h8
`define OFS_PINS_A        4'h9
`define OFS_PINS_B        4'hA
`define OFS_STATUS        4'hB

// Function control fields
`define FC_EXTERNAL_CLOCK_SELECT        0
`define FC_CLK_OUT        1
`define FC_REMAP          2
`define FC_SERIAL_EN      3
`define FC_XCK_OUT        4
`define FC_ACO_OUT        5
`define FC_RST_GPIO       6

// Analog control fields
`define AC_CH_LSB         0
`define AC_CH_MSB         2
`define AC_CMP_EN         6
`define AC_ADC_EN         7

// Status fields
`define ST_PROG           0
`define ST_EXTERNAL_CLOCK_SELECT        1
`define ST_REMAP          2

// Pin indices: port A bits 0..7, port B bits 0..3 at 8..11
`define PIN_PA0           0
`define PIN_PA1           1
`define PIN_PA2           2
`define PIN_PA3           3
`define PIN_PA4           4
`define PIN_PA5           5
`define PIN_PB1           9
`define PIN_PB2           10
`define PIN_PB3           11

`define RST_BYTE          8'h00
`define RST_PINS          12'h000

`endif

// ===== pin_cell.v
// One pad's output selection, input buffer gating and output flops
`timescale 1ns/1ps
`default_nettype none
module pin_cell (
  // Clock and resets
  input  wire ref_clk,
  input  wire srst,
  input  wire reset_cond,
  // Selection
  input  wire force_input,
  input  wire port_val,
  input  wire port_dir,
  input  wire alt_sel,
  input  wire alt_val,
  input  wire keep_buffer,
  input  wire didr_bit,
  // Pad
  input  wire pad_in,
  output reg  pad_out,
  output reg  pad_oe,
  output reg  ibuf_en,
  output reg  in_q
);
  wire buf_on;
  assign buf_on = ~didr_bit | keep_buffer;

  // driver released at once on reset_cond, no clock needed; srst and force_input wait for a clock edge
  always @(posedge ref_clk or posedge reset_cond) begin
    if (reset_cond) begin
      pad_oe <= 1'b0;
    end else if (srst || force_input) begin
      pad_oe <= 1'b0;
    end else begin
      pad_oe <= alt_sel ? 1'b1 : port_dir;
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      pad_out <= 1'b0;
      ibuf_en <= 1'b1;
      in_q    <= 1'b0;
    end else begin
      pad_out <= alt_sel ? alt_val : port_val;
      ibuf_en <= buf_on;
      in_q    <= pad_in & buf_on;
    end
  end
endmodule
`default_nettype wire

// ===== pin_mux_monitor.sv
// Assertion checker for the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_regs.vh"
module pin_mux_monitor (
  // Clock and resets
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        reset_cond,
  // Register writes
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  // Peripherals
  input wire logic        prog_active,
  input wire logic        clock_output_pin_fn,
  input wire logic        timer_compare_output_a,
  input wire logic        timer_oca_en,
  input wire logic        timer_ocb_en,
  input wire logic        comparator_result_out,
  // Pins
  input wire logic [11:0] pad_out,
  input wire logic [11:0] pad_oe,
  input wire logic [11:0] pad_ibuf_en,
  input wire logic        reset_pin_weak,
  input wire logic [7:0]  analog_channel_switch
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst || reset_cond);
  // Shadow registers, loaded on the same edge as the design's
  logic [7:0] dir_q, fn_q, didr_q, pc_q, ac_q;
  logic       ok;
  assign ok = !prog_active && !reset_cond;
  always @(posedge ref_clk) begin
    if (srst) begin
      {dir_q, fn_q, didr_q, pc_q, ac_q} <= 40'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_PORTA_DIR:   dir_q <= reg_wdata;
        `OFS_FUNC_CTRL:   fn_q <= {1'b0, reg_wdata[6:0]};
        `OFS_DIDR:        didr_q <= reg_wdata;
        `OFS_PIN_CHANGE_IRQ_LINES_A:     pc_q <= reg_wdata;
        `OFS_ANALOG_CTRL: ac_q <= reg_wdata;
        default: ;
      endcase
    end
  end
  a_cond_release: assert property (disable iff (srst)
    reset_cond |-> pad_oe == 12'h000) else $error("pad driven in reset");
  a_prog_inputs: assert property (
    prog_active |=> pad_oe == 12'h000) else $error("pad driven in prog");
  a_srst_inputs: assert property (
    $past(srst) |-> pad_oe == 12'h000) else $error("pad driven in srst");
  a_clk_out_wins: assert property ($past(fn_q[`FC_CLK_OUT] && ok)
    |-> pad_oe[`PIN_PB1] && pad_out[`PIN_PB1] == $past(clock_output_pin_fn))
    else $error("clock out lost pin");
  a_remap_moves: assert property (
    $past(fn_q[`FC_REMAP] && timer_oca_en && ok) |-> pad_oe[`PIN_PA3]
    && pad_out[`PIN_PA3] == $past(timer_compare_output_a))
    else $error("compare not remapped");
  a_external_clock_select_buf: assert property ($past(fn_q[`FC_EXTERNAL_CLOCK_SELECT])
    |-> pad_ibuf_en[0] && !analog_channel_switch[0])
    else $error("clock pin buffer or channel");
  a_pin_change_irq_lines_buf: assert property ($past(didr_q[1])
    |-> pad_ibuf_en[1] == $past(pc_q[1])) else $error("buffer gating");
  a_ocb_analog: assert property ($past(timer_ocb_en &&
    !fn_q[`FC_REMAP] && ac_q[`AC_ADC_EN] && ac_q[2:0] == 3'h1)
    |-> analog_channel_switch[1]) else $error("channel lost");
  a_aco_keeps: assert property ($past(fn_q[`FC_ACO_OUT] && ok)
    |-> pad_oe[11] && pad_ibuf_en[11]
    && pad_out[11] == $past(comparator_result_out)) else $error("aco pin");
  a_port_default: assert property ($past(fn_q == 8'h00 && ok
    && !timer_oca_en && !timer_ocb_en) |-> pad_oe[7:0] ==
    ($past(dir_q) & 8'hFB)) else $error("port direction");
  a_reset_pin: assert property (
    reset_pin_weak == $past(fn_q[`FC_RST_GPIO])) else $error("weak io");
  cover property (fn_q[`FC_REMAP] && timer_oca_en);
  cover property (prog_active);
  cover property (fn_q[`FC_ACO_OUT] && didr_q[7]);
endmodule
bind port_pin_function_mux pin_mux_monitor i_mon (.*);
`default_nettype wire

// ===== periph_model.sv
// Behavioural model of the peripherals competing for the pins
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  // Clock and bench control
  input  wire logic ref_clk,
  input  wire logic oca_on,
  input  wire logic ocb_on,
  // Outputs toward the pins
  output logic      clock_output_pin_fn,
  output logic      timer_compare_output_a,
  output logic      timer_oca_en,
  output logic      timer_compare_output_b,
  output logic      timer_ocb_en,
  output logic      serial_transmit_line,
  output logic      serial_sync_clock,
  output logic      comparator_result_out
);
  // Sources follow bits, inverted bits or the parity of one counter, so a stale or swapped one shows
  logic [2:0] cnt_q = 3'h0;
  always @(posedge ref_clk) cnt_q <= cnt_q + 3'h1;
  assign clock_output_pin_fn = cnt_q[0];
  assign timer_compare_output_a = cnt_q[1];
  assign timer_compare_output_b = cnt_q[2];
  assign serial_transmit_line = ~cnt_q[1];
  assign serial_sync_clock = ~cnt_q[0];
  assign comparator_result_out = ^cnt_q;
  assign timer_oca_en = oca_on;
  assign timer_ocb_en = ocb_on;
endmodule
`default_nettype wire

// ===== port_pin_function_mux_tb.sv
// Self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_regs.vh"
module port_pin_function_mux_tb;
  logic ref_clk = 1'b0, srst = 1'b1, reset_cond = 1'b0, prog_active = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, oca_on = 1'b0, ocb_on = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, analog_channel_switch;
  logic [11:0] ext_lvl = 12'h010, pad_in, pad_out, pad_oe, pad_ibuf_en;
  logic [11:0] pin_change_irq_lines;
  logic reset_pin_weak, clock_input_pin_fn, prog_if_clock, prog_if_data;
  logic timer_count_input, timer_capture_input, serial_receive_line;
  logic external_irq_zero, comparator_pos_input, comparator_neg_input;
  logic clock_output_pin_fn, timer_compare_output_a, timer_oca_en;
  logic timer_compare_output_b, timer_ocb_en, serial_transmit_line;
  logic serial_sync_clock, comparator_result_out;
  int fail_count = 0;
  int checked = 0;
  // A driven pad reads back its own drive
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
  port_pin_function_mux i_dut (.*);
  periph_model i_periph (.*);
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic settle;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata === e, "read data");
  endtask
  function automatic logic pick(input int src);
    case (src)
      0: return clock_output_pin_fn;
      1: return timer_compare_output_a;
      2: return timer_compare_output_b;
      3: return comparator_result_out;
      4: return serial_sync_clock;
      default: return serial_transmit_line;
    endcase
  endfunction
  task automatic follow(input int idx, input int src);
    logic v;
    @(negedge ref_clk);
    v = pick(src);
    @(negedge ref_clk);
    chk(pad_oe[idx] && pad_out[idx] === v, "pin source");
  endtask
  task automatic t_default;
    chk(pad_oe === 12'h000 && pad_ibuf_en === 12'hFFF, "reset");
    wr(`OFS_PORTA_DATA, 8'hA5);
    wr(`OFS_PORTA_DIR, 8'hFF);
    settle;
    chk(pad_oe[7:0] === 8'hFB, "port dir");
    chk((pad_out[7:0] & 8'hFB) === 8'hA1, "port data");
    rd(`OFS_PORTA_DIR, 8'hFF);
    wr(`OFS_FUNC_CTRL, 8'hC0);
    settle;
    chk(reset_pin_weak && pad_oe[2] === 1'b1, "reset pin io");
    rd(`OFS_FUNC_CTRL, 8'h40);
    rd(4'hC, 8'h00);
  endtask
  task automatic t_force;
    @(posedge ref_clk);
    prog_active <= 1'b1;
    settle;
    chk(pad_oe === 12'h000, "prog drives");
    @(posedge ref_clk);
    prog_active <= 1'b0;
    settle;
    chk(pad_oe[7:0] === 8'hFF, "after prog");
    @(posedge ref_clk);
    reset_cond <= 1'b1;
    #1;
    chk(pad_oe === 12'h000, "reset condition");
    @(posedge ref_clk);
    reset_cond <= 1'b0;
    srst <= 1'b1;
    settle;
    chk(pad_oe === 12'h000 && pad_ibuf_en === 12'hFFF, "srst");
    @(posedge ref_clk);
    srst <= 1'b0;
  endtask
  task automatic t_timer;
    @(posedge ref_clk);
    oca_on <= 1'b1;
    follow(`PIN_PB1, 1);
    wr(`OFS_FUNC_CTRL, 8'h02);
    follow(`PIN_PB1, 0);
    wr(`OFS_FUNC_CTRL, 8'h04);
    follow(`PIN_PA3, 1);
    chk(pad_oe[`PIN_PB1] === 1'b0, "old compare pin");
    chk(timer_capture_input === 1'b1, "capture pin");
    rd(`OFS_STATUS, 8'h04);
    @(posedge ref_clk);
    ocb_on <= 1'b1;
    follow(`PIN_PA5, 2);
  endtask
  task automatic t_analog;
    wr(`OFS_DIDR, 8'h83);
    wr(`OFS_PIN_CHANGE_IRQ_LINES_A, 8'h02);
    wr(`OFS_FUNC_CTRL, 8'h29); // channel six stays unused
    wr(`OFS_ANALOG_CTRL, 8'h80);
    settle;
    chk(pad_ibuf_en[1:0] === 2'b11, "buffers kept");
    chk(analog_channel_switch[0] === 1'b0, "channel zero");
    chk(pad_ibuf_en[11] && pad_oe[`PIN_PB2] === 1'b1, "aco, tx");
    follow(`PIN_PB3, 3);
    wr(`OFS_PIN_CHANGE_IRQ_LINES_A, 8'h00);
    wr(`OFS_ANALOG_CTRL, 8'h81);
    settle;
    chk(pad_ibuf_en[1] === 1'b0, "buffer off");
    chk(analog_channel_switch === 8'h02 && pad_oe[1], "ocb ch");
  endtask
  task automatic t_inputs;
    logic [11:0] lv;
    logic        ext;
    wr(`OFS_FUNC_CTRL, 8'h19);
    follow(`PIN_PB1, 4);
    follow(`PIN_PB2, 5);
    @(posedge ref_clk);
    oca_on <= 1'b0;
    ocb_on <= 1'b0;
    wr(`OFS_PIN_CHANGE_IRQ_LINES_A, 8'hFF);
    wr(`OFS_PIN_CHANGE_IRQ_LINES_B, 8'h0B);
    wr(`OFS_ANALOG_CTRL, 8'h40);
    // Patterns chosen so each route except PA0 reads a different level once; PA0 is high in both
    for (int k = 0; k < 2; k++) begin
      ext = (k == 0);
      lv = ext ? 12'h3A5 : 12'hC5B;
      wr(`OFS_FUNC_CTRL, ext ? 8'h01 : 8'h08);
      @(posedge ref_clk);
      ext_lvl <= lv;
      settle;
      settle;
      chk(clock_input_pin_fn === (lv[0] & ext), "clock in");
      chk(timer_count_input === lv[0], "count pin");
      chk(serial_receive_line === (lv[11] & ~ext), "receive");
      chk(external_irq_zero === lv[9], "irq zero");
      chk(pin_change_irq_lines === (lv & 12'hBFF), "pin change");
      chk(comparator_neg_input === lv[1], "cmp neg");
      rd(`OFS_PINS_A, lv[7:0]);
      if (ext) begin
        rd(`OFS_PINS_B, {4'h0, lv[11:8]});
        rd(`OFS_STATUS, 8'h02);
      end else begin
        chk(comparator_pos_input === lv[0], "cmp pos");
      end
    end
    @(posedge ref_clk);
    prog_active <= 1'b1;
    settle;
    settle;
    chk(prog_if_clock === lv[0] && prog_if_data === lv[1], "prog if");
    rd(`OFS_STATUS, 8'h01);
    @(posedge ref_clk);
    prog_active <= 1'b0;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge ref_clk);
    fail_count++;
    results;
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    t_default;
    t_force;
    t_timer;
    t_analog;
    t_inputs;
    results;
  end
endmodule
`default_nettype wire
